// File: logic/word_math_unit.sv
// Sixteen-bit word arithmetic and logic unit with an APB register slave
//
// Implementation choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps

module word_math_unit (
   // Clock and reset
   input  wire logic                                    clock,
   input  wire logic                                    rst_n,
   // APB slave
   input  wire logic                                    psel,
   input  wire logic                                    penable,
   input  wire logic                                    pwrite,
   input  wire logic [word_math_pkg::APB_AW-1:0]        paddr,
   input  wire logic [word_math_pkg::APB_DW-1:0]        pwdata,
   output logic      [word_math_pkg::APB_DW-1:0]        prdata,
   output logic                                         pready,
   output logic                                         pslverr,
   // Operands and trigger from surrounding logic
   input  wire logic [word_math_pkg::WORD_W-1:0]        operand_a_in,
   input  wire logic [word_math_pkg::WORD_W-1:0]        operand_b_in,
   input  wire logic                                    operand_b_driven,
   input  wire logic                                    trigger_in,
   // Result and write-back to operand A storage
   output logic      [word_math_pkg::WORD_W-1:0]        result_word_out,
   output logic      [word_math_pkg::WORD_W-1:0]        operand_a_write_data,
   output logic                                         operand_a_write_strobe
);

   // ************************************************************
   // Helpers
   // ************************************************************

   // Operation legality decode, used only by the commit check; the datapath decodes on its own
   function automatic logic op_is_legal(input logic [word_math_pkg::OP_W-1:0] op);
      begin
         op_is_legal = (op <= word_math_pkg::OP_SHR);
      end
   endfunction

   // Full datapath; every arm is cut to the word width
   function automatic logic [word_math_pkg::WORD_W-1:0] compute(
      input logic [word_math_pkg::OP_W-1:0]   op,
      input logic [word_math_pkg::WORD_W-1:0] a,
      input logic [word_math_pkg::WORD_W-1:0] b);
      logic [2*word_math_pkg::WORD_W-1:0] wide;
      begin
         wide = '0;
         unique case (op)
            word_math_pkg::OP_ADD: wide = {16'h0000, a} + {16'h0000, b};
            word_math_pkg::OP_SUB: wide = {16'h0000, a} - {16'h0000, b};
            word_math_pkg::OP_MUL: wide = {16'h0000, a} * {16'h0000, b};
            word_math_pkg::OP_DIV: wide = {16'h0000, a / b};
            word_math_pkg::OP_AND: wide = {16'h0000, a & b};
            word_math_pkg::OP_OR:  wide = {16'h0000, a | b};
            word_math_pkg::OP_XOR: wide = {16'h0000, a ^ b};
            word_math_pkg::OP_SHL: wide = {16'h0000, a << b};
            word_math_pkg::OP_SHR: wide = {16'h0000, a >> b};
            default:               wide = '0;
         endcase
         // Low half only, so results wrap modulo 65536
         compute = wide[word_math_pkg::WORD_W-1:0];
      end
   endfunction

   // ************************************************************
   // Registers
   // ************************************************************
   logic [word_math_pkg::OP_W-1:0]    op_select;
   logic                              edge_qualified_enable;
   logic                              write_back_enable;
   logic [word_math_pkg::WORD_W-1:0]  operand_b_constant;
   logic                              div_zero_seen;
   logic                              eval_seen;
   logic                              trigger_prev;

   logic [word_math_pkg::OP_W-1:0]    next_op_select;
   logic                              next_edge_qualified_enable;
   logic                              next_write_back_enable;
   logic [word_math_pkg::WORD_W-1:0]  next_operand_b_constant;
   logic                              next_div_zero_seen;
   logic                              next_eval_seen;
   logic                              next_trigger_prev;
   logic [word_math_pkg::WORD_W-1:0]  next_result_word_out;
   logic [word_math_pkg::WORD_W-1:0]  next_operand_a_write_data;
   logic                              next_operand_a_write_strobe;
   logic [word_math_pkg::APB_DW-1:0]  next_prdata;
   logic                              next_pready;
   logic                              next_pslverr;

   // ************************************************************
   // Datapath evaluation
   // ************************************************************
   logic [word_math_pkg::WORD_W-1:0]  operand_b;
   logic                              trigger_rise;
   logic                              evaluate;
   logic                              div_by_zero;
   logic                              commit;

   // Operand B falls back to the constant when unconnected
   assign operand_b    = operand_b_driven ? operand_b_in : operand_b_constant;
   assign trigger_rise = trigger_in & ~trigger_prev;
   // Clock is the scan cycle; edge mode narrows it to trigger rises
   assign evaluate     = edge_qualified_enable ? trigger_rise : 1'b1;
   assign div_by_zero  = (op_select == word_math_pkg::OP_DIV) &&
                         (operand_b == word_math_pkg::RST_WORD);
   // Illegal codes and divide by zero leave result, write-back and eval flag untouched; divide by zero sets its sticky flag
   assign commit       = evaluate && op_is_legal(op_select) && !div_by_zero;

   // Next result, write-back and edge history
   always_comb begin
      next_trigger_prev           = trigger_in;
      next_result_word_out        = result_word_out;
      next_operand_a_write_data   = operand_a_write_data;
      next_operand_a_write_strobe = 1'b0;
      if (commit) begin
         next_result_word_out = compute(op_select, operand_a_in, operand_b);
         if (write_back_enable) begin
            // One strobe per evaluation: every cycle, or once per edge
            next_operand_a_write_data   = compute(op_select, operand_a_in, operand_b);
            next_operand_a_write_strobe = 1'b1;
         end
      end
   end

   // ************************************************************
   // APB slave
   // ************************************************************
   logic access;
   logic addr_ok;
   logic wr_fire;

   // One wait state: pready rises on the second access cycle
   assign access  = psel && penable;
   assign wr_fire = access && pready && pwrite;
   assign addr_ok = (paddr == word_math_pkg::ADDR_CONTROL) ||
                    (paddr == word_math_pkg::ADDR_B_CONST) ||
                    (paddr == word_math_pkg::ADDR_RESULT)  ||
                    (paddr == word_math_pkg::ADDR_STATUS);

   // Bus answer and register writes
   always_comb begin
      next_pready                = access && !pready;
      next_pslverr               = access && !pready && !addr_ok;
      next_prdata                = word_math_pkg::RST_BUS;
      next_op_select             = op_select;
      next_edge_qualified_enable = edge_qualified_enable;
      next_write_back_enable     = write_back_enable;
      next_operand_b_constant    = operand_b_constant;
      next_div_zero_seen         = div_zero_seen;
      next_eval_seen             = eval_seen;
      if (access && !pready && !pwrite) begin
         unique case (paddr)
            word_math_pkg::ADDR_CONTROL: begin
               next_prdata[word_math_pkg::CTRL_OP_LSB +: word_math_pkg::OP_W] = op_select;
               next_prdata[word_math_pkg::CTRL_EDGE_BIT] = edge_qualified_enable;
               next_prdata[word_math_pkg::CTRL_WB_BIT]   = write_back_enable;
            end
            word_math_pkg::ADDR_B_CONST: begin
               next_prdata[word_math_pkg::WORD_W-1:0] = operand_b_constant;
            end
            word_math_pkg::ADDR_RESULT: begin
               next_prdata[word_math_pkg::WORD_W-1:0] = result_word_out;
            end
            word_math_pkg::ADDR_STATUS: begin
               next_prdata[word_math_pkg::STAT_DIVZ_BIT] = div_zero_seen;
               next_prdata[word_math_pkg::STAT_EVAL_BIT] = eval_seen;
            end
            default: begin
               next_prdata = word_math_pkg::RST_BUS;
            end
         endcase
      end
      if (wr_fire && paddr == word_math_pkg::ADDR_CONTROL) begin
         next_op_select = pwdata[word_math_pkg::CTRL_OP_LSB +: word_math_pkg::OP_W];
         next_edge_qualified_enable = pwdata[word_math_pkg::CTRL_EDGE_BIT];
         next_write_back_enable     = pwdata[word_math_pkg::CTRL_WB_BIT];
      end
      if (wr_fire && paddr == word_math_pkg::ADDR_B_CONST) begin
         next_operand_b_constant = pwdata[word_math_pkg::WORD_W-1:0];
      end
      // Sticky status: write one clears, but a new event wins
      if (wr_fire && paddr == word_math_pkg::ADDR_STATUS) begin
         if (pwdata[word_math_pkg::STAT_DIVZ_BIT]) begin
            next_div_zero_seen = 1'b0;
         end
         if (pwdata[word_math_pkg::STAT_EVAL_BIT]) begin
            next_eval_seen = 1'b0;
         end
      end
      if (evaluate && div_by_zero) begin
         next_div_zero_seen = 1'b1;
      end
      if (commit) begin
         next_eval_seen = 1'b1;
      end
   end

   // ************************************************************
   // State registers
   // ************************************************************

   // Synchronous reset; all outputs are flops
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         op_select              <= word_math_pkg::RST_OP;
         edge_qualified_enable  <= 1'b0;
         write_back_enable      <= 1'b0;
         operand_b_constant     <= word_math_pkg::RST_WORD;
         div_zero_seen          <= 1'b0;
         eval_seen              <= 1'b0;
         trigger_prev           <= 1'b0;
         result_word_out        <= word_math_pkg::RST_WORD;
         operand_a_write_data   <= word_math_pkg::RST_WORD;
         operand_a_write_strobe <= 1'b0;
         prdata                 <= word_math_pkg::RST_BUS;
         pready                 <= 1'b0;
         pslverr                <= 1'b0;
      end else begin
         op_select              <= next_op_select;
         edge_qualified_enable  <= next_edge_qualified_enable;
         write_back_enable      <= next_write_back_enable;
         operand_b_constant     <= next_operand_b_constant;
         div_zero_seen          <= next_div_zero_seen;
         eval_seen              <= next_eval_seen;
         trigger_prev           <= next_trigger_prev;
         result_word_out        <= next_result_word_out;
         operand_a_write_data   <= next_operand_a_write_data;
         operand_a_write_strobe <= next_operand_a_write_strobe;
         prdata                 <= next_prdata;
         pready                 <= next_pready;
         pslverr                <= next_pslverr;
      end
   end

endmodule

// File: include/word_math_pkg.sv
// Constants shared by the word math unit and its bench
package word_math_pkg;

   // ************************************************************
   // Data widths
   // ************************************************************
   localparam int WORD_W = 16;
   localparam int APB_AW = 12;
   localparam int APB_DW = 32;
   localparam int OP_W   = 4;

   // ************************************************************
   // Register byte addresses
   // ************************************************************
   localparam logic [APB_AW-1:0] ADDR_CONTROL   = 12'h000;
   localparam logic [APB_AW-1:0] ADDR_B_CONST   = 12'h004;
   localparam logic [APB_AW-1:0] ADDR_RESULT    = 12'h008;
   localparam logic [APB_AW-1:0] ADDR_STATUS    = 12'h00C;

   // ************************************************************
   // Control register fields
   // ************************************************************
   localparam int CTRL_OP_LSB   = 0;
   localparam int CTRL_EDGE_BIT = 4;
   localparam int CTRL_WB_BIT   = 5;

   // Status register fields
   localparam int STAT_DIVZ_BIT = 0;
   localparam int STAT_EVAL_BIT = 1;

   // ************************************************************
   // Operation codes
   // ************************************************************
   localparam logic [OP_W-1:0] OP_ADD = 4'h0;
   localparam logic [OP_W-1:0] OP_SUB = 4'h1;
   localparam logic [OP_W-1:0] OP_MUL = 4'h2;
   localparam logic [OP_W-1:0] OP_DIV = 4'h3;
   localparam logic [OP_W-1:0] OP_AND = 4'h4;
   localparam logic [OP_W-1:0] OP_OR  = 4'h5;
   localparam logic [OP_W-1:0] OP_XOR = 4'h6;
   localparam logic [OP_W-1:0] OP_SHL = 4'h7;
   localparam logic [OP_W-1:0] OP_SHR = 4'h8;

   // ************************************************************
   // Reset values
   // ************************************************************
   localparam logic [OP_W-1:0]   RST_OP     = 4'h0;
   localparam logic [WORD_W-1:0] RST_WORD   = 16'h0000;
   localparam logic [APB_DW-1:0] RST_BUS    = 32'h0000_0000;

endpackage

// File: verification/word_math_unit_assertions.sv
// Port-level checks for the word math unit
`timescale 1ns/1ps
module word_math_unit_assertions (
   // Clock, reset and APB
   input wire logic        clock,
   input wire logic        rst_n,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // Datapath
   input wire logic [15:0] operand_a_in,
   input wire logic [15:0] operand_b_in,
   input wire logic        operand_b_driven,
   input wire logic        trigger_in,
   input wire logic [15:0] result_word_out,
   input wire logic [15:0] operand_a_write_data,
   input wire logic        operand_a_write_strobe
);
   // ************************************************************
   // Control shadow
   // ************************************************************
   logic [5:0] ctrl;
   logic [5:0] next_ctrl;
   logic       rise;

   // Follows control writes at the completion edge, as the slave does
   always_comb begin
      next_ctrl = ctrl;
      if (psel && penable && pready && pwrite && paddr == word_math_pkg::ADDR_CONTROL) begin
         next_ctrl = pwdata[5:0];
      end
   end

   // Registered shadow
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         ctrl <= 6'h00;
      end else begin
         ctrl <= next_ctrl;
      end
   end

   // ************************************************************
   // Properties
   // ************************************************************
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);

   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_err_with_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   a_wb_data: assert property (operand_a_write_strobe |-> operand_a_write_data == result_word_out)
      else $error("write-back word differs from result");
   a_edge_hold: assert property (ctrl[4] && !(trigger_in && !$past(trigger_in))
      |=> $stable(result_word_out)) else $error("result moved without trigger rise");
   a_edge_wb_rise: assert property (operand_a_write_strobe && $past(ctrl[4])
      |-> $past(trigger_in) && !$past(trigger_in, 2)) else $error("edge write-back off a rise");
   a_free_wb: assert property (!ctrl[4] && ctrl[5] && ctrl[3:0] <= word_math_pkg::OP_SHR
      && ctrl[3:0] != word_math_pkg::OP_DIV |=> operand_a_write_strobe)
      else $error("write-back missing in a scan cycle");
   a_add_sum: assert property (!ctrl[4] && ctrl[3:0] == word_math_pkg::OP_ADD
      && operand_b_driven |=> result_word_out == 16'($past(operand_a_in) + $past(operand_b_in)))
      else $error("sum wrong");
   a_mul_prod: assert property (!ctrl[4] && ctrl[3:0] == word_math_pkg::OP_MUL
      && operand_b_driven |=> result_word_out == 16'($past(operand_a_in) * $past(operand_b_in)))
      else $error("product wrong");
   a_divz_hold: assert property (ctrl[3:0] == word_math_pkg::OP_DIV && operand_b_driven
      && operand_b_in == 16'h0000 |=> $stable(result_word_out)) else $error("divide by zero moved");

   // Main scenarios reached
   assign rise = trigger_in;
   c_edge: cover property (ctrl[4] && rise && !$past(rise));
   c_wb: cover property (operand_a_write_strobe);
   c_err: cover property (pslverr);
endmodule

bind word_math_unit word_math_unit_assertions word_math_unit_assertions_inst (
   .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .operand_a_in(operand_a_in), .operand_b_in(operand_b_in),
   .operand_b_driven(operand_b_driven), .trigger_in(trigger_in),
   .result_word_out(result_word_out), .operand_a_write_data(operand_a_write_data),
   .operand_a_write_strobe(operand_a_write_strobe)
);

// File: verification/word_reg_model.sv
// Word register of the surrounding logic, feeding operand A
`timescale 1ns/1ps
module word_reg_model (
   // Clock
   input  wire logic        clock,
   // Preload from the bench
   input  wire logic        load,
   input  wire logic [15:0] load_value,
   // Write-back from the unit
   input  wire logic        write_strobe,
   input  wire logic [15:0] write_data,
   output logic      [15:0] word
);
   // Writable store on operand A; preload wins so the bench can seed it
   always_ff @(posedge clock) begin
      if (load) begin
         word <= load_value;
      end else if (write_strobe) begin
         word <= write_data;
      end
   end
endmodule

// File: verification/word_math_unit_test.sv
// Self-checking bench for the word math unit
`timescale 1ns/1ps
module word_math_unit_test;
   logic        clock, rst_n, psel, penable, pwrite, b_drv, trig, load, pready, pslverr, strobe;
   logic        err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] a_word, b_in, load_val, result, wr_data;
   int          mismatches, n_checks, cycles;

   // ************************************************************
   // Design and operand A register
   // ************************************************************
   word_math_unit word_math_unit_inst (
      .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .operand_a_in(a_word), .operand_b_in(b_in), .operand_b_driven(b_drv),
      .trigger_in(trig), .result_word_out(result), .operand_a_write_data(wr_data),
      .operand_a_write_strobe(strobe));
   word_reg_model word_reg_model_inst (.clock(clock), .load(load), .load_value(load_val),
      .write_strobe(strobe), .write_data(wr_data), .word(a_word));

   // Free-running clock
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end

   // Hang guard, well above the expected run length
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 4000) begin
         mismatches++;
         end_of_test();
      end
   end

   // ************************************************************
   // Shared tasks
   // ************************************************************
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   // Seeds the operand A register
   task automatic load_a(input logic [15:0] v);
      @(posedge clock);
      load <= 1'b1;
      load_val <= v;
      @(posedge clock);
      load <= 1'b0;
   endtask

   // One trigger pulse, then let the write-back land
   task automatic pulse;
      @(posedge clock);
      trig <= 1'b1;
      @(posedge clock);
      trig <= 1'b0;
      repeat (2) @(posedge clock);
   endtask

   // Reference result, kept apart from the design
   function automatic logic [15:0] ref_op(input int op, input logic [15:0] a, b);
      case (op)
         0: return a + b;
         1: return a - b;
         2: return a * b;
         3: return a / b;
         4: return a & b;
         5: return a | b;
         6: return a ^ b;
         7: return a << b;
         default: return a >> b;
      endcase
   endfunction

   // ************************************************************
   // Scenarios
   // ************************************************************
   task automatic t_reset;
      apb(1'b0, word_math_pkg::ADDR_CONTROL, 32'h0);
      chk(rd, 32'h0, "control reset");
      apb(1'b0, word_math_pkg::ADDR_B_CONST, 32'h0);
      chk(rd, 32'h0, "constant reset");
      apb(1'b0, 12'h010, 32'h0);
      chk({31'h0, err}, 32'h1, "unmapped not refused");
      $display("t_reset done");
   endtask

   // Every op code, with wrap and shift boundary operands
   task automatic t_ops;
      logic [15:0] ta[9];
      logic [15:0] tb[9];
      ta = '{16'hFFFF, 16'h0003, 16'h0100, 16'h0064, 16'hF0F0, 16'hF0F0, 16'hF0F0, 16'h8001, 16'h000E};
      tb = '{16'h0002, 16'h0005, 16'h0100, 16'h0007, 16'h0FF0, 16'h0FF0, 16'h0FF0, 16'h0001, 16'h0001};
      for (int i = 0; i < 9; i++) begin
         b_in <= tb[i];
         load_a(ta[i]);
         apb(1'b1, word_math_pkg::ADDR_CONTROL, {28'h0, 4'(i)});
         repeat (2) @(posedge clock);
         chk(result, ref_op(i, ta[i], tb[i]), "op result");
      end
      $display("t_ops done");
   endtask

   // Constant operand when B is undriven, then divide by zero
   task automatic t_const;
      b_drv <= 1'b0;
      load_a(16'h0007);
      apb(1'b1, word_math_pkg::ADDR_B_CONST, 32'h5);
      apb(1'b1, word_math_pkg::ADDR_CONTROL, 32'h0);
      repeat (2) @(posedge clock);
      chk(result, 16'h000C, "constant operand");
      b_drv <= 1'b1;
      b_in <= 16'h0000;
      apb(1'b1, word_math_pkg::ADDR_CONTROL, 32'h3);
      repeat (3) @(posedge clock);
      chk(result, 16'h0007, "divide by zero moved");
      apb(1'b0, word_math_pkg::ADDR_STATUS, 32'h0);
      chk(rd[0], 1'b1, "divide by zero flag");
      // Clear collides with a fresh divide by zero each cycle: the event must win
      apb(1'b1, word_math_pkg::ADDR_STATUS, 32'h1);
      apb(1'b0, word_math_pkg::ADDR_STATUS, 32'h0);
      chk(rd[0], 1'b1, "flag lost to clear");
      // Illegal op code must leave the result untouched
      apb(1'b1, word_math_pkg::ADDR_CONTROL, 32'h9);
      repeat (3) @(posedge clock);
      chk(result, 16'h0007, "illegal op moved result");
      $display("t_const done");
   endtask

   // Edge mode with write-back into the operand register
   task automatic t_edge;
      load_a(16'h000A);
      apb(1'b1, word_math_pkg::ADDR_CONTROL, 32'h30);
      b_in <= 16'h0003;
      repeat (4) @(posedge clock);
      chk(result, 16'h0007, "result moved without trigger");
      chk(a_word, 16'h000A, "write-back without trigger");
      pulse();
      chk(a_word, 16'h000D, "first write-back");
      chk(strobe, 1'b0, "strobe too long");
      pulse();
      chk(result, 16'h0010, "second result");
      apb(1'b0, word_math_pkg::ADDR_RESULT, 32'h0);
      chk(rd, 32'h10, "result register");
      $display("t_edge done");
   endtask

   // Write-back every scan cycle without edge mode
   task automatic t_free;
      apb(1'b1, word_math_pkg::ADDR_CONTROL, 32'h20);
      repeat (2) @(posedge clock);
      for (int i = 0; i < 3; i++) begin
         @(posedge clock);
         chk(strobe, 1'b1, "scan write-back");
      end
      $display("t_free done");
   endtask

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      rst_n = 1'b0;
      {psel, penable, pwrite, trig, load} = 5'h00;
      b_drv = 1'b1;
      paddr = 12'h000;
      pwdata = 32'h0;
      {b_in, load_val} = 32'h0;
      {mismatches, n_checks, cycles} = '0;
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      t_reset();
      t_ops();
      t_const();
      t_edge();
      t_free();
      end_of_test();
   end
endmodule
